/* File: mbx_crc16.sv */
// One-byte step of the Modbus RTU CRC-16
`timescale 1ns/1ps
`default_nettype none
`include "mbx_regs.svh"

module mbx_crc16
    import mbx_pkg::*;
(
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc_out
);

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < `MBX_CRC_BITS; i++)
        begin
            r = r[0] ? ((r >> 1) ^ `MBX_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    assign crc_out = crc_step(crc_in, data);

endmodule
`default_nettype wire

/* File: mbx_exception_commit.sv */
// Query checker, exception responder and commit engine of the slave
// Notes on behaviour
// - Every non-broadcast query gets a matching answer, or an exception on error.
// - Exception frame: slave address, function code, exception code, CRC-16.
// - Exception function code is the query function code plus 80h.
// - Unsupported function answers exception code 01h.
// - Nonexistent coil or register address answers exception code 02h.
// - Badly formatted query data answers exception code 03h.
// - Written value outside the register's permitted range answers 21h.
// - Run-locked write, commit in undervoltage, write while tripped: answer 22h.
// - Write to a read-only coil or register answers 22h.
// - Broadcast multi-register write is carried out with no answer sent.
// - Multi-write starting address is one below the real address; add one.
// - Register writes land in volatile storage only until a commit.
// - Single write of 0000 to register 0900h recalculates motor constants only.
// - Writing 0001 stores all registers to nonvolatile memory, no recalculation.
// - Any other value both recalculates and stores.
// - Coil 001Ah shows write in progress for the whole commit.
`timescale 1ns/1ps
`default_nettype none
`include "mbx_regs.svh"

module mbx_exception_commit
    import mbx_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        q_valid,
    output logic             q_ready,
    input  wire mbx_query_s  q,
    output logic      [15:0] map_addr,
    input  wire mbx_map_s    map_st,
    input  wire mbx_drive_s  drive,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [7:0]  tx_data,
    output logic             tx_last,
    output logic             resp_ok,
    output logic             vol_wr,
    output logic      [15:0] vol_wr_addr,
    output logic      [15:0] vol_wr_count,
    output logic      [15:0] vol_wr_data,
    output logic             recalc_req,
    output logic             store_req,
    input  wire logic        recalc_done,
    input  wire logic        store_done,
    output logic             write_busy
);

    mbx_state_e  state;
    mbx_query_s  qr;
    logic [7:0]  exc;
    logic [7:0]  next_exc;
    logic [1:0]  idx;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic        pend_recalc;
    logic        pend_store;
    logic        bcast;
    logic        commit_hit;
    logic        tx_fire;

    function automatic logic fn_supported(input logic [7:0] f);
        return f == `MBX_FN_RD_COILS || f == `MBX_FN_RD_REGS || f == `MBX_FN_WR_COIL
            || f == `MBX_FN_WR_REG || f == `MBX_FN_DIAG || f == `MBX_FN_WR_COILS
            || f == `MBX_FN_WR_REGS;
    endfunction

    function automatic logic fn_writes(input logic [7:0] f);
        return f == `MBX_FN_WR_COIL || f == `MBX_FN_WR_REG
            || f == `MBX_FN_WR_COILS || f == `MBX_FN_WR_REGS;
    endfunction

    // Multi-item writes carry a start field one below the first real address
    function automatic logic [15:0] real_addr(input mbx_query_s x);
        if (x.func == `MBX_FN_WR_REGS || x.func == `MBX_FN_WR_COILS)
            return x.addr + `MBX_ADDR_SKEW;
        return x.addr;
    endfunction

    function automatic logic format_bad(input mbx_query_s x);
        logic [15:0] want;
        want = {x.count[14:0], 1'b0};
        case (x.func)
            `MBX_FN_WR_REGS:  return x.count == `MBX_NONE16 || want != {8'h00, x.nbytes};
            `MBX_FN_WR_COILS: return x.count == `MBX_NONE16 || x.nbytes == `MBX_NONE8;
            `MBX_FN_WR_COIL:  return x.data != `MBX_COIL_ON && x.data != `MBX_COIL_OFF;
            default:          return 1'b0;
        endcase
    endfunction

    assign bcast      = qr.slave == `MBX_BCAST_ADDR;
    assign commit_hit = qr.func == `MBX_FN_WR_REG && qr.addr == `MBX_COMMIT_ADDR;
    assign write_busy = pend_recalc | pend_store;
    assign q_ready    = state == MBX_IDLE;
    assign tx_valid   = state == MBX_SEND || state == MBX_CRC_LO || state == MBX_CRC_HI;
    assign tx_last    = state == MBX_CRC_HI;
    assign tx_fire    = tx_valid & tx_ready;

    // Checks are ordered so that the first failing one names the error
    always_comb
    begin
        next_exc = `MBX_EXC_NONE;
        if (!fn_supported(qr.func))
            next_exc = `MBX_EXC_FUNC;
        else if (!map_st.addr_ok)
            next_exc = `MBX_EXC_ADDR;
        else if (format_bad(qr))
            next_exc = `MBX_EXC_FORMAT;
        else if (fn_writes(qr.func) && map_st.read_only)
            next_exc = `MBX_EXC_REFUSED;
        else if (commit_hit && (drive.undervolt || write_busy))
            next_exc = `MBX_EXC_REFUSED;
        else if (fn_writes(qr.func) && (drive.uv_trip || (drive.running && map_st.run_locked)))
            next_exc = `MBX_EXC_REFUSED;
        else if (fn_writes(qr.func) && !map_st.range_ok)
            next_exc = `MBX_EXC_RANGE;
    end

    mbx_crc16 u_crc
    (
        .crc_in  (crc),
        .data    (tx_data),
        .crc_out (next_crc)
    );

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state <= MBX_IDLE;
            idx   <= `MBX_IDX_FIRST;
        end
        else
        begin
            case (state)
                MBX_IDLE:
                    if (q_valid)
                        state <= MBX_CHECK;
                MBX_CHECK:
                    // Broadcasts never answer, not even with an exception
                    if (next_exc != `MBX_EXC_NONE && !bcast)
                    begin
                        state <= MBX_SEND;
                        idx   <= `MBX_IDX_FIRST;
                    end
                    else
                        state <= MBX_IDLE;
                MBX_SEND:
                    if (tx_fire)
                    begin
                        idx <= idx + `MBX_IDX_STEP;
                        if (idx == `MBX_IDX_CODE)
                            state <= MBX_CRC_LO;
                    end
                MBX_CRC_LO:
                    if (tx_fire)
                        state <= MBX_CRC_HI;
                MBX_CRC_HI:
                    if (tx_fire)
                        state <= MBX_IDLE;
                default:
                    state <= MBX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            qr       <= '0;
            map_addr <= `MBX_NONE16;
        end
        else if (state == MBX_IDLE && q_valid)
        begin
            qr       <= q;
            map_addr <= real_addr(q);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            exc     <= `MBX_EXC_NONE;
            tx_data <= `MBX_NONE8;
            crc     <= `MBX_CRC_INIT;
        end
        else if (state == MBX_CHECK)
        begin
            exc     <= next_exc;
            tx_data <= qr.slave;
            crc     <= `MBX_CRC_INIT;
        end
        else if (tx_fire)
        begin
            crc <= next_crc;
            case (state)
                MBX_SEND:
                    if (idx == `MBX_IDX_FIRST)
                        tx_data <= qr.func | `MBX_EXC_FLAG;
                    else if (idx == `MBX_IDX_FUNC)
                        tx_data <= exc;
                    else
                        tx_data <= next_crc[7:0];
                MBX_CRC_LO:
                    tx_data <= crc[15:8];
                default:
                    tx_data <= tx_data;
            endcase
        end
    end

    // Writes go to volatile storage; only a commit reaches nonvolatile memory
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            resp_ok      <= 1'b0;
            vol_wr       <= 1'b0;
            vol_wr_addr  <= `MBX_NONE16;
            vol_wr_count <= `MBX_NONE16;
            vol_wr_data  <= `MBX_NONE16;
        end
        else
        begin
            resp_ok <= state == MBX_CHECK && next_exc == `MBX_EXC_NONE && !bcast;
            vol_wr  <= state == MBX_CHECK && next_exc == `MBX_EXC_NONE
                       && fn_writes(qr.func) && !commit_hit;
            if (state == MBX_CHECK)
            begin
                vol_wr_addr  <= map_addr;
                vol_wr_count <= qr.func == `MBX_FN_WR_REGS ? qr.count : `MBX_ADDR_SKEW;
                vol_wr_data  <= qr.data;
            end
        end
    end

    // Commit engine; a done pulse in the same cycle as a new request loses
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            recalc_req  <= 1'b0;
            store_req   <= 1'b0;
            pend_recalc <= 1'b0;
            pend_store  <= 1'b0;
        end
        else
        begin
            recalc_req <= 1'b0;
            store_req  <= 1'b0;
            if (state == MBX_CHECK && commit_hit && next_exc == `MBX_EXC_NONE)
            begin
                recalc_req  <= qr.data != `MBX_COMMIT_STORE;
                store_req   <= qr.data != `MBX_COMMIT_RECALC;
                pend_recalc <= qr.data != `MBX_COMMIT_STORE;
                pend_store  <= qr.data != `MBX_COMMIT_RECALC;
            end
            else
            begin
                if (recalc_done)
                    pend_recalc <= 1'b0;
                if (store_done)
                    pend_store <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_check_commit(logic [15:0] v);
        state == MBX_CHECK && commit_hit && next_exc == `MBX_EXC_NONE && qr.data == v;
    endsequence

    sequence s_frame_head;
        state == MBX_SEND && idx == `MBX_IDX_FIRST && tx_ready
        ##1 state == MBX_SEND && tx_ready;
    endsequence

    AST_ANSWER_OWED: assert property (
        state == MBX_CHECK && !bcast |=> (resp_ok ^ (state == MBX_SEND)))
        else $error("Non-broadcast query got no single answer");

    AST_FRAME_TAIL: assert property (
        s_frame_head |=> state == MBX_SEND && idx == `MBX_IDX_CODE)
        else $error("Exception frame did not reach its code byte");

    AST_FUNC_FLAG: assert property (
        state == MBX_SEND && idx == `MBX_IDX_FUNC |-> tx_data == (qr.func | `MBX_EXC_FLAG))
        else $error("Exception function code lacks the flag");

    AST_UNSUPPORTED: assert property (
        state == MBX_CHECK && !fn_supported(qr.func) |=> exc == `MBX_EXC_FUNC)
        else $error("Unsupported function not answered with 01h");

    AST_NO_ADDR: assert property (
        state == MBX_CHECK && fn_supported(qr.func) && !map_st.addr_ok |=> exc == `MBX_EXC_ADDR)
        else $error("Missing address not answered with 02h");

    AST_READ_ONLY: assert property (
        state == MBX_CHECK && next_exc != `MBX_EXC_ADDR && next_exc != `MBX_EXC_FORMAT
        && next_exc != `MBX_EXC_FUNC && fn_writes(qr.func) && map_st.read_only
        |=> exc == `MBX_EXC_REFUSED)
        else $error("Read-only write not refused with 22h");

    AST_BCAST_SILENT: assert property (
        state == MBX_CHECK && bcast |=> !tx_valid && !resp_ok)
        else $error("Broadcast query produced an answer");

    AST_ADDR_SKEW: assert property (
        state == MBX_IDLE && q_valid && q.func == `MBX_FN_WR_REGS
        |=> map_addr == $past(q.addr) + `MBX_ADDR_SKEW)
        else $error("Multi-write start address not advanced by one");

    AST_RECALC_ONLY: assert property (
        s_check_commit(`MBX_COMMIT_RECALC) |=> recalc_req && !store_req)
        else $error("Commit 0000 must recalculate only");

    AST_STORE_ONLY: assert property (
        s_check_commit(`MBX_COMMIT_STORE) |=> store_req && !recalc_req)
        else $error("Commit 0001 must store only");

    AST_BUSY_HELD: assert property (
        store_req |-> write_busy until_with store_done)
        else $error("Write busy dropped before store finished");

    AST_LAST_BOUND: assert property (
        state == MBX_CHECK ##1 state == MBX_SEND |-> ##[1:64] tx_last)
        else $error("Exception frame never reached its CRC");

endmodule
`default_nettype wire

/* File: mbx_far_model.sv */
// Far-side model: register map lookup, byte sink and the recalc and store engines
`timescale 1ns/1ps
`default_nettype none

module mbx_far_model
    import mbx_pkg::*;
#(
    parameter int DONE_LAT = 6
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] map_addr,
    output mbx_map_s         map_st,
    input  wire logic        slow,
    input  wire logic        range_bad,
    output logic             tx_ready,
    input  wire logic        recalc_req,
    input  wire logic        store_req,
    output logic             recalc_done,
    output logic             store_done
);
    int rc_cnt;
    int st_cnt;

    // Map answers combinationally; low page read-only, page 01h locked in run
    always_comb
    begin
        map_st.addr_ok    = (map_addr < 16'h1000);
        map_st.read_only  = (map_addr[15:8] == 8'h00);
        map_st.run_locked = (map_addr[15:8] == 8'h01);
        map_st.range_ok   = !range_bad;
    end

    // Slow sink accepts only every other cycle to exercise held bytes
    always_ff @(posedge mclk)
    begin
        if (rst)
            tx_ready <= 1'b1;
        else
            tx_ready <= slow ? !tx_ready : 1'b1;
    end

    // Commit engines take a long time, so busy must stand across it
    always_ff @(posedge mclk)
    begin
        recalc_done <= 1'b0;
        store_done  <= 1'b0;
        if (rst)
        begin
            rc_cnt <= 0;
            st_cnt <= 0;
        end
        else
        begin
            if (recalc_req)
                rc_cnt <= DONE_LAT;
            else if (rc_cnt > 0)
                rc_cnt <= rc_cnt - 1;
            if (rc_cnt == 1)
                recalc_done <= 1'b1;
            if (store_req)
                st_cnt <= DONE_LAT;
            else if (st_cnt > 0)
                st_cnt <= st_cnt - 1;
            if (st_cnt == 1)
                store_done <= 1'b1;
        end
    end
endmodule

`default_nettype wire

/* File: mbx_pkg.sv */
// Types shared by the exception and commit block
package mbx_pkg;

    typedef struct packed {
        logic [7:0]  slave;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] count;
        logic [7:0]  nbytes;
        logic [15:0] data;
    } mbx_query_s;

    typedef struct packed {
        logic addr_ok;
        logic read_only;
        logic run_locked;
        logic range_ok;
    } mbx_map_s;

    typedef struct packed {
        logic running;
        logic undervolt;
        logic uv_trip;
    } mbx_drive_s;

    typedef enum logic [2:0] {
        MBX_IDLE   = 3'b000,
        MBX_CHECK  = 3'b001,
        MBX_SEND   = 3'b011,
        MBX_CRC_LO = 3'b010,
        MBX_CRC_HI = 3'b110
    } mbx_state_e;

endpackage

/* File: mbx_regs.svh */
// Register offsets, codes and fixed values of the exception and commit block
`ifndef MBX_REGS_SVH
`define MBX_REGS_SVH

`define MBX_FN_RD_COILS     8'h01
`define MBX_FN_RD_REGS      8'h03
`define MBX_FN_WR_COIL      8'h05
`define MBX_FN_WR_REG       8'h06
`define MBX_FN_DIAG         8'h08
`define MBX_FN_WR_COILS     8'h0f
`define MBX_FN_WR_REGS      8'h10

`define MBX_EXC_FLAG        8'h80
`define MBX_EXC_NONE        8'h00
`define MBX_EXC_FUNC        8'h01
`define MBX_EXC_ADDR        8'h02
`define MBX_EXC_FORMAT      8'h03
`define MBX_EXC_RANGE       8'h21
`define MBX_EXC_REFUSED     8'h22

`define MBX_BCAST_ADDR      8'h00
`define MBX_COMMIT_ADDR     16'h0900
`define MBX_COMMIT_RECALC   16'h0000
`define MBX_COMMIT_STORE    16'h0001
`define MBX_BUSY_COIL       16'h001a
`define MBX_COIL_ON         16'hff00
`define MBX_COIL_OFF        16'h0000
`define MBX_ADDR_SKEW       16'h0001
`define MBX_NONE16          16'h0000
`define MBX_NONE8           8'h00

`define MBX_CRC_INIT        16'hffff
`define MBX_CRC_POLY        16'ha001
`define MBX_CRC_BITS        8

`define MBX_IDX_FUNC        2'h1
`define MBX_IDX_CODE        2'h2
`define MBX_IDX_FIRST       2'h0
`define MBX_IDX_STEP        2'h1

`endif

/* File: modbus_exception_and_commit_tb.sv */
// Self-checking testbench of the exception responder and commit engine
`timescale 1ns/1ps
`default_nettype none

module modbus_exception_and_commit_tb
    import mbx_pkg::*;
;
    logic        mclk, rst, q_valid, q_ready, tx_valid, tx_ready, tx_last, resp_ok;
    logic        vol_wr, recalc_req, store_req, recalc_done, store_done, write_busy;
    logic        slow, range_bad, s_ok, s_vw, s_rc, s_st, s_tx;
    logic [7:0]  tx_data;
    logic [15:0] map_addr, vol_wr_addr, vol_wr_count, vol_wr_data, s_map;
    logic [7:0]  fr [5];
    mbx_query_s  q;
    mbx_map_s    map_st;
    mbx_drive_s  drive;
    int          n_fail, tests_run, nb, nl;

    mbx_exception_commit DUT (.mclk(mclk), .rst(rst), .q_valid(q_valid), .q_ready(q_ready),
        .q(q), .map_addr(map_addr), .map_st(map_st), .drive(drive), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .resp_ok(resp_ok),
        .vol_wr(vol_wr), .vol_wr_addr(vol_wr_addr), .vol_wr_count(vol_wr_count),
        .vol_wr_data(vol_wr_data), .recalc_req(recalc_req), .store_req(store_req),
        .recalc_done(recalc_done), .store_done(store_done), .write_busy(write_busy));

    mbx_far_model far (.mclk(mclk), .rst(rst), .map_addr(map_addr), .map_st(map_st),
        .slow(slow), .range_bad(range_bad), .tx_ready(tx_ready), .recalc_req(recalc_req),
        .store_req(store_req), .recalc_done(recalc_done), .store_done(store_done));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = !mclk;
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Own reflected CRC so expectations never lean on the design's helper
    function automatic logic [15:0] crc3(input logic [7:0] a, b, c);
        logic [15:0] r;
        logic [7:0]  d [3];
        r = 16'hffff;
        d = '{a, b, c};
        for (int i = 0; i < 3; i++)
        begin
            r = r ^ {8'h00, d[i]};
            for (int k = 0; k < 8; k++)
                r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
        end
        return r;
    endfunction

    // Offer one query at a falling edge and snapshot the outputs at the second falling edge after take
    task automatic send(input logic [7:0] sl, fn, input logic [15:0] ad, cn,
                        input logic [7:0] nbt, input logic [15:0] dt);
        int i;
        i = 0;
        while (q_ready !== 1'b1 && i < 50)
        begin
            @(negedge mclk);
            i++;
        end
        q = '{sl, fn, ad, cn, nbt, dt};
        q_valid = 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        q_valid = 1'b0;
        s_map = map_addr;
        @(posedge mclk);
        @(negedge mclk);
        {s_ok, s_vw, s_rc, s_st, s_tx} = {resp_ok, vol_wr, recalc_req, store_req, tx_valid};
    endtask

    task automatic get_frame();
        int i;
        nb = 0;
        nl = 0;
        i = 0;
        while (i < 40)
        begin
            if (tx_valid && tx_ready && nb < 5)
            begin
                fr[nb] = tx_data;
                nb++;
                // The last flag must ride on the fifth byte, not merely end the wait
                if (tx_last)
                begin
                    nl = nb;
                    i = 40;
                end
            end
            @(negedge mclk);
            i++;
        end
    endtask

    task automatic exc_case(input logic [7:0] fn, input logic [15:0] ad, cn,
                            input logic [7:0] nbt, input logic [15:0] dt,
                            input logic [2:0] drv, input logic rb, sl, input logic [7:0] code);
        logic [15:0] c;
        drive = drv;
        range_bad = rb;
        slow = sl;
        send(8'h11, fn, ad, cn, nbt, dt);
        check(s_tx, 1'b1);
        check(s_ok, 1'b0);
        get_frame();
        c = crc3(8'h11, fn + 8'h80, code);
        check(nb, 5);
        check(nl, 5);
        check(fr[0], 8'h11);
        check(fr[1], fn + 8'h80);
        check(fr[2], code);
        check({fr[4], fr[3]}, c);
        check(q_ready, 1'b1);
        drive = 3'b000;
        range_bad = 1'b0;
        slow = 1'b0;
    endtask

    task automatic commit_case(input logic [15:0] dt, input logic rc, st);
        int i;
        send(8'h11, 8'h06, 16'h0900, 16'h0001, 8'h02, dt);
        check({s_rc, s_st, s_ok, s_vw}, {rc, st, 2'b10});
        check(write_busy, 1'b1);
        i = 0;
        while (write_busy === 1'b1 && i < 30)
        begin
            @(negedge mclk);
            i++;
        end
        check(i > 3 && i < 30, 1'b1);
    endtask

    initial
    begin
        #(25 * 5000);
        n_fail++;
        conclude();
    end

    initial
    begin
        n_fail = 0;
        tests_run = 0;
        rst = 1'b1;
        q_valid = 1'b0;
        q = '0;
        drive = 3'b000;
        slow = 1'b0;
        range_bad = 1'b0;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        check({q_ready, tx_valid, write_busy}, 3'b100);
        exc_case(8'h07, 16'h0500, 16'h0001, 8'h02, 16'h0000, 3'b000, 0, 0, 8'h01);
        exc_case(8'h03, 16'h2000, 16'h0001, 8'h00, 16'h0000, 3'b000, 0, 1, 8'h02);
        exc_case(8'h10, 16'h0500, 16'h0002, 8'h02, 16'h1234, 3'b000, 0, 0, 8'h03);
        exc_case(8'h05, 16'h0500, 16'h0001, 8'h00, 16'h1234, 3'b000, 0, 0, 8'h03);
        exc_case(8'h06, 16'h0500, 16'h0001, 8'h02, 16'hffff, 3'b000, 1, 1, 8'h21);
        exc_case(8'h06, 16'h0010, 16'h0001, 8'h02, 16'h0001, 3'b000, 0, 0, 8'h22);
        exc_case(8'h06, 16'h0105, 16'h0001, 8'h02, 16'h0001, 3'b100, 0, 0, 8'h22);
        exc_case(8'h06, 16'h0500, 16'h0001, 8'h02, 16'h0001, 3'b001, 0, 1, 8'h22);
        exc_case(8'h06, 16'h0900, 16'h0001, 8'h02, 16'h0001, 3'b010, 0, 0, 8'h22);
        send(8'h11, 8'h03, 16'h0500, 16'h0002, 8'h00, 16'h0000);
        check({s_ok, s_tx, s_vw}, 3'b100);
        // Master sends byte count, raw address one below the first register
        send(8'h11, 8'h10, 16'h0500, 16'h0002, 8'h04, 16'h00a5);
        check(s_map, 16'h0501);
        check({s_vw, s_ok, s_tx}, 3'b110);
        check(vol_wr_addr, 16'h0501);
        check(vol_wr_count, 16'h0002);
        check(vol_wr_data, 16'h00a5);
        // Multi-coil write carries the same one-below start field
        send(8'h11, 8'h0f, 16'h0505, 16'h0006, 8'h02, 16'h1700);
        check(s_map, 16'h0506);
        check({s_vw, s_ok, s_tx}, 3'b110);
        send(8'h00, 8'h10, 16'h0600, 16'h0001, 8'h02, 16'h005a);
        check({s_vw, s_ok, s_tx}, 3'b100);
        check(vol_wr_addr, 16'h0601);
        send(8'h00, 8'h07, 16'h0500, 16'h0001, 8'h02, 16'h0000);
        check({s_ok, s_tx}, 2'b00);
        // Recalculation requested after a control constant changed, commits kept few
        commit_case(16'h0000, 1'b1, 1'b0);
        commit_case(16'h0001, 1'b0, 1'b1);
        send(8'h11, 8'h06, 16'h0900, 16'h0001, 8'h02, 16'h1234);
        check({s_rc, s_st, write_busy}, 3'b111);
        exc_case(8'h06, 16'h0900, 16'h0001, 8'h02, 16'h0001, 3'b000, 0, 0, 8'h22);
        repeat (20) @(negedge mclk);
        check(write_busy, 1'b0);
        conclude();
    end
endmodule

`default_nettype wire
